// ---- rtl/bsie_core.sv ----
// Bit set, bit test and skip instruction execution with Avalon-MM register access
`timescale 1ns/1ps
`include "bsie_map.svh"
module bsie_core #(
    parameter int IO_COUNT = `BSIE_IO_COUNT,
    parameter int MEM_AW   = `BSIE_MEM_AW
) (
    // Clock, reset and enable
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    // Avalon-MM slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // Port data registers
    output logic      [`BSIE_DW-1:0]    port_a,
    output logic      [`BSIE_DW-1:0]    port_b,
    // Architectural state
    output logic      [`BSIE_DW-1:0]    working_register,
    output bsie_pkg::bsie_flags_t       arith_flags
);
    import bsie_pkg::*;

    localparam int IW = $clog2(IO_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Subtract with borrow style flags, used by compares and decrements
    function automatic bsie_alu_t alu_sub(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] diff;
        bsie_alu_t  r;
        diff                     = {1'b0, a} - {1'b0, b};
        r.res                    = diff[7:0];
        r.flags.zero_flag        = (diff[7:0] == '0);
        r.flags.carry_flag       = diff[8];
        r.flags.half_carry_flag  = (a[3:0] < b[3:0]);
        r.flags.sign_wrap_flag   = (a[7] ^ b[7]) & (diff[7] ^ a[7]);
        return r;
    endfunction

    // Add with carry out flags, used by increments
    function automatic bsie_alu_t alu_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        logic [4:0] low;
        bsie_alu_t  r;
        sum                      = {1'b0, a} + {1'b0, b};
        low                      = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        r.res                    = sum[7:0];
        r.flags.zero_flag        = (sum[7:0] == '0);
        r.flags.carry_flag       = sum[8];
        r.flags.half_carry_flag  = low[4];
        r.flags.sign_wrap_flag   = ~(a[7] ^ b[7]) & (sum[7] ^ a[7]);
        return r;
    endfunction

    // Byte lane merge for partial writes
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Bus offset falls on an IO data register
    function automatic logic io_hit(input logic [7:0] a);
        return (a >= `BSIE_REG_IO_BASE) &&
               (a < (`BSIE_REG_IO_BASE + 8'(IO_COUNT) * `BSIE_REG_IO_STEP));
    endfunction

    // Index of the IO data register at a bus offset
    function automatic logic [IW-1:0] io_index(input logic [7:0] a);
        return IW'((a - `BSIE_REG_IO_BASE) >> 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    bsie_state_t               state_q;
    bsie_cmd_t                 cmd_q;
    logic [`BSIE_DW-1:0]       acc_q;
    bsie_flags_t               flags_q;
    logic [`BSIE_DW-1:0]       io_q [IO_COUNT];
    logic [`BSIE_DW-1:0]       result_q;
    logic                      skip_pend_q;
    logic                      skipped_q;
    logic                      wait_q;
    logic [31:0]               rdata_q;
    logic [`BSIE_DW-1:0]       mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [7:0]  bus_addr;
    logic        bus_can;
    logic        wr_done;
    logic [31:0] wr_word;
    logic [31:0] rd_mux;

    // Low address bits ignored; registers are aligned words
    assign bus_addr = {avs_address[7:2], 2'b00};
    // Writes wait while an instruction runs so they never race it
    assign bus_can  = avs_read | (avs_write & (state_q == st_idle));
    assign wr_done  = avs_write & ~wait_q;

    // Read value of the addressed register, zero for unmapped offsets
    always_comb begin
        rd_mux = '0;
        unique case (bus_addr)
            `BSIE_REG_CMD:    rd_mux = cmd_q;
            `BSIE_REG_ACC:    rd_mux = 32'(acc_q);
            `BSIE_REG_FLAGS:  rd_mux = 32'(flags_q);
            `BSIE_REG_STATUS: begin
                rd_mux[`BSIE_STAT_BUSY]    = (state_q != st_idle);
                rd_mux[`BSIE_STAT_PEND]    = skip_pend_q;
                rd_mux[`BSIE_STAT_SKIPPED] = skipped_q;
            end
            `BSIE_REG_RESULT: rd_mux = 32'(result_q);
            default: begin
                if (io_hit(bus_addr)) begin
                    rd_mux = 32'(io_q[io_index(bus_addr)]);
                end
            end
        endcase
    end

    // Write data merged lane by lane onto the addressed register
    always_comb begin
        wr_word = be_merge(rd_mux, avs_writedata, avs_byteenable);
    end

    // Waitrequest drops for one cycle once a request can be served
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 1'b1;
        end else if (ce) begin
            if (wait_q && bus_can) begin
                wait_q <= 1'b0;
            end else begin
                wait_q <= 1'b1;
            end
        end
    end

    // Read data captured as waitrequest drops, stands through the last edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (ce && wait_q && avs_read) begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_waitrequest  = wait_q;
    assign avs_readdata     = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Execution

    logic                ex_go;
    logic                io_ok;
    logic [`BSIE_DW-1:0] io_byte;
    logic [`BSIE_DW-1:0] mask;
    bsie_alu_t           alu;
    logic                ex_acc_we;
    logic                ex_flags_we;
    logic                ex_io_we;
    logic [`BSIE_DW-1:0] ex_io_data;
    logic                ex_mem_we;
    logic [`BSIE_DW-1:0] ex_mem_data;
    logic                ex_res_we;
    logic                ex_skip;

    // An instruction behind a taken skip runs its cycles but changes nothing
    assign ex_go   = (state_q == st_exec) & ~skip_pend_q;
    assign io_ok   = (32'(cmd_q.addr) < IO_COUNT);
    assign io_byte = io_ok ? io_q[IW'(cmd_q.addr)] : '0;
    assign mask    = `BSIE_BIT_ONE << cmd_q.bit_idx;

    // Effects of the latched instruction; memory operand is valid in st_exec
    always_comb begin
        alu         = '0;
        ex_acc_we   = 1'b0;
        ex_flags_we = 1'b0;
        ex_io_we    = 1'b0;
        ex_io_data  = io_byte;
        ex_mem_we   = 1'b0;
        ex_mem_data = mem_rdata;
        ex_res_we   = 1'b0;
        ex_skip     = 1'b0;
        unique case (cmd_q.op)
            clear_bit_op_io: begin
                ex_io_we   = io_ok;
                ex_io_data = io_byte & ~mask;
            end
            assert_bit_op_io: begin
                ex_io_we   = io_ok;
                ex_io_data = io_byte | mask;
            end
            clear_bit_op_mem: begin
                ex_mem_we   = 1'b1;
                ex_mem_data = mem_rdata & ~mask;
            end
            assert_bit_op_mem: begin
                ex_mem_we   = 1'b1;
                ex_mem_data = mem_rdata | mask;
            end
            cmp_imm_skip: begin
                alu         = alu_sub(acc_q, cmd_q.imm);
                ex_flags_we = 1'b1;
                ex_skip     = (acc_q == cmd_q.imm);
            end
            cmp_mem_skip: begin
                alu         = alu_sub(acc_q, mem_rdata);
                ex_flags_we = 1'b1;
                ex_skip     = (acc_q == mem_rdata);
            end
            test_low_skip_io:   ex_skip = ~io_byte[cmd_q.bit_idx];
            test_high_skip_io:  ex_skip = io_byte[cmd_q.bit_idx];
            test_low_skip_mem:  ex_skip = ~mem_rdata[cmd_q.bit_idx];
            test_high_skip_mem: ex_skip = mem_rdata[cmd_q.bit_idx];
            inc_acc_skip: begin
                alu         = alu_add(acc_q, `BSIE_ONE);
                ex_acc_we   = 1'b1;
                ex_flags_we = 1'b1;
                ex_skip     = alu.flags.zero_flag;
            end
            dec_acc_skip: begin
                alu         = alu_sub(acc_q, `BSIE_ONE);
                ex_acc_we   = 1'b1;
                ex_flags_we = 1'b1;
                ex_skip     = alu.flags.zero_flag;
            end
            inc_mem_skip: begin
                alu         = alu_add(mem_rdata, `BSIE_ONE);
                ex_mem_we   = 1'b1;
                ex_mem_data = alu.res;
                ex_flags_we = 1'b1;
                ex_skip     = alu.flags.zero_flag;
            end
            dec_mem_skip: begin
                alu         = alu_sub(mem_rdata, `BSIE_ONE);
                ex_mem_we   = 1'b1;
                ex_mem_data = alu.res;
                ex_flags_we = 1'b1;
                ex_skip     = alu.flags.zero_flag;
            end
            mem_load: begin
                ex_mem_we   = 1'b1;
                ex_mem_data = cmd_q.imm;
            end
            mem_fetch: ex_res_we = 1'b1;
            default: begin
                // No operation and undefined codes change nothing
            end
        endcase
    end

    // Sequence: latch command, read memory operand, apply effects
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= st_idle;
        end else if (ce) begin
            unique case (state_q)
                st_idle: begin
                    if (wr_done && bus_addr == `BSIE_REG_CMD) begin
                        state_q <= st_read;
                    end
                end
                st_read: state_q <= st_exec;
                st_exec: state_q <= st_idle;
            endcase
        end
    end

    // Command register, reserved bits forced to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= '0;
        end else if (ce && wr_done && bus_addr == `BSIE_REG_CMD) begin
            cmd_q      <= bsie_cmd_t'(wr_word);
            cmd_q.rsv0 <= '0;
            cmd_q.rsv1 <= '0;
            cmd_q.rsv2 <= '0;
        end
    end

    // Working register: bus load when idle, else increment or decrement result
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= `BSIE_ACC_RST;
        end else if (ce) begin
            if (wr_done && bus_addr == `BSIE_REG_ACC) begin
                acc_q <= wr_word[`BSIE_DW-1:0];
            end else if (ex_go && ex_acc_we) begin
                acc_q <= alu.res;
            end
        end
    end

    // Flags: compares leave the working register alone but update all four
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_q <= '0;
        end else if (ce) begin
            if (wr_done && bus_addr == `BSIE_REG_FLAGS) begin
                flags_q <= bsie_flags_t'(wr_word[$bits(bsie_flags_t)-1:0]);
            end else if (ex_go && ex_flags_we) begin
                flags_q <= alu.flags;
            end
        end
    end

    // IO data registers, one per index; bit ops rewrite the whole byte
    for (genvar g = 0; g < IO_COUNT; g++) begin : g_io
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                io_q[g] <= `BSIE_IO_RST;
            end else if (ce) begin
                if (wr_done && io_hit(bus_addr) && io_index(bus_addr) == IW'(g)) begin
                    io_q[g] <= wr_word[`BSIE_DW-1:0];
                end else if (ex_go && ex_io_we && IW'(cmd_q.addr) == IW'(g)) begin
                    io_q[g] <= ex_io_data;
                end
            end
        end
    end

    // Fetched memory byte for software
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_q <= '0;
        end else if (ce && ex_go && ex_res_we) begin
            result_q <= mem_rdata;
        end
    end

    // A taken skip arms; the next instruction consumes it and is cancelled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            skip_pend_q <= 1'b0;
            skipped_q   <= 1'b0;
        end else if (ce && state_q == st_exec) begin
            skip_pend_q <= ~skip_pend_q & ex_skip;
            skipped_q   <= skip_pend_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory

    bsie_mem #(
        .DW (`BSIE_DW),
        .AW (MEM_AW)
    ) u_mem (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .we      (ex_go & ex_mem_we),
        .waddr   (MEM_AW'(cmd_q.addr)),
        .wdata   (ex_mem_data),
        .raddr   (MEM_AW'(cmd_q.addr)),
        .rdata_q (mem_rdata)
    );

    // Outputs straight from registers
    assign port_a           = io_q[0];
    assign port_b           = io_q[1];
    assign working_register = acc_q;
    assign arith_flags      = flags_q;

endmodule

// ---- rtl/bsie_map.svh ----
// Register map, field constants and reset values of the bit and skip block
`ifndef BSIE_MAP_SVH
`define BSIE_MAP_SVH
// Operation
// - Clear IO bit: selected IO register bit becomes 0, others and flags kept.
// - Assert IO bit: selected IO register bit becomes 1, others and flags kept.
// - Clear memory bit: selected data byte bit becomes 0, others and flags kept.
// - Assert memory bit: selected data byte bit becomes 1, others and flags kept.
// - Compare with immediate: skip next instruction when working register equals it.
// - Both compares set all four flags as working register minus operand, register kept.
// - Compare with memory: skip next instruction when working register equals byte.
// - Test IO bit low: skip next when selected IO bit is 0, flags kept.
// - Test IO bit high: skip next when selected IO bit is 1, flags kept.
// - Test memory bit low: skip next when selected byte bit is 0, flags kept.
// - Test memory bit high: skip next when selected byte bit is 1, flags kept.
// - Increment working register, set all four flags, skip next when result zero.
// - Decrement working register, set all four flags, skip next when result zero.
// - Increment memory byte, write back, set four flags, skip next on zero.
// - Decrement memory byte, write back, set four flags, skip next on zero.

// Register byte offsets on the bus
`define BSIE_REG_CMD      8'h00
`define BSIE_REG_ACC      8'h04
`define BSIE_REG_FLAGS    8'h08
`define BSIE_REG_STATUS   8'h0c
`define BSIE_REG_RESULT   8'h10
`define BSIE_REG_IO_BASE  8'h20
`define BSIE_REG_IO_STEP  8'h04

// Sizes
`define BSIE_IO_COUNT     4
`define BSIE_MEM_AW       6
`define BSIE_DW           8

// Status register bit positions
`define BSIE_STAT_BUSY    0
`define BSIE_STAT_PEND    1
`define BSIE_STAT_SKIPPED 2

// Reset values and fixed operands
`define BSIE_ACC_RST      8'h00
`define BSIE_IO_RST       8'h00
`define BSIE_ONE          8'h01
`define BSIE_BIT_ONE      8'h01

`endif

// ---- rtl/bsie_mem.sv ----
// Data memory of the bit and skip execution block, registered read port
`timescale 1ns/1ps
module bsie_mem #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    // Clock, reset and enable
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_q
);

    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // Array carries no reset so it can map onto RAM
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Read data registered; a write in the same cycle shows on the next read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= mem_q[raddr];
        end
    end

endmodule

// ---- rtl/bsie_pkg.sv ----
// Types shared by the bit and skip execution block
package bsie_pkg;

    // Instruction codes, in the command register op field
    typedef enum logic [4:0] {
        op_nop,
        clear_bit_op_io,
        assert_bit_op_io,
        clear_bit_op_mem,
        assert_bit_op_mem,
        cmp_imm_skip,
        cmp_mem_skip,
        test_low_skip_io,
        test_high_skip_io,
        test_low_skip_mem,
        test_high_skip_mem,
        inc_acc_skip,
        dec_acc_skip,
        inc_mem_skip,
        dec_mem_skip,
        mem_load,
        mem_fetch
    } bsie_op_t;

    // Arithmetic flags, zero flag in bit 0
    typedef struct packed {
        logic sign_wrap_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic zero_flag;
    } bsie_flags_t;

    // Command register layout
    typedef struct packed {
        logic [7:0] imm;
        logic [1:0] rsv2;
        logic [5:0] addr;
        logic [4:0] rsv1;
        logic [2:0] bit_idx;
        logic [2:0] rsv0;
        bsie_op_t   op;
    } bsie_cmd_t;

    // Result of the adder with its flags
    typedef struct packed {
        logic [7:0]  res;
        bsie_flags_t flags;
    } bsie_alu_t;

    // Execution sequence
    typedef enum logic [1:0] {
        st_idle,
        st_read,
        st_exec
    } bsie_state_t;

endpackage

// ---- verification/bsie_core_props.sv ----
// Port-level assertions for the bit and skip execution block
`timescale 1ns/1ps
`include "bsie_map.svh"
module bsie_core_props
    import bsie_pkg::*;
(
    // Clock and reset
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                ce,
    // Bus
    input wire logic [7:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    // State
    input wire logic [`BSIE_DW-1:0] port_a,
    input wire logic [`BSIE_DW-1:0] port_b,
    input wire logic [`BSIE_DW-1:0] working_register,
    input wire bsie_flags_t         arith_flags
);
    ////////////////////////////////////////////////////////////////
    // Command completion and the bits an IO bit op keeps
    logic      cmd_done;
    bsie_cmd_t cw;
    logic [7:0] keep_q;
    assign cmd_done = ce && avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00;
    assign cw = bsie_cmd_t'(avs_writedata);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) keep_q <= 8'h00;
        else if (cmd_done) keep_q <= ~(8'h01 << cw.bit_idx);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    // Handshake: one-cycle answer
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low twice");
    property p_wait_req;
        !avs_waitrequest |-> (avs_read || avs_write);
    endproperty
    a_wait_req: assert property (p_wait_req) else $error("wait low, no request");
    property p_read_prompt;
        ce && $rose(avs_read) |=> !avs_waitrequest;
    endproperty
    a_read_prompt: assert property (p_read_prompt) else $error("read not answered");
    // Bit and test ops leave the flags alone
    property p_bit_flags;
        cmd_done && cw.op inside {[clear_bit_op_io:assert_bit_op_mem],
            [test_low_skip_io:test_high_skip_mem]} |=> $stable(arith_flags) [*3];
    endproperty
    a_bit_flags: assert property (p_bit_flags)
        else $error("bit op moved flags");
    property p_cmp_acc;
        cmd_done && cw.op inside {cmp_imm_skip, cmp_mem_skip} |=> $stable(working_register) [*3];
    endproperty
    a_cmp_acc: assert property (p_cmp_acc)
        else $error("compare moved register");
    property p_io_others;
        cmd_done && cw.addr == 6'h00 && cw.op inside {clear_bit_op_io, assert_bit_op_io}
            |=> (((port_a ^ $past(port_a)) & keep_q) == 8'h00) [*3];
    endproperty
    a_io_others: assert property (p_io_others)
        else $error("other IO bits moved");
    property p_inc_acc;
        cmd_done && cw.op == inc_acc_skip |-> ##3
            (working_register == $past(working_register, 3)) ||
            (working_register == $past(working_register, 3) + 8'h01 &&
             arith_flags.zero_flag == (working_register == 8'h00));
    endproperty
    a_inc_acc: assert property (p_inc_acc)
        else $error("increment wrong");
    property p_dec_acc;
        cmd_done && cw.op == dec_acc_skip |-> ##3
            (working_register == $past(working_register, 3)) ||
            (working_register == $past(working_register, 3) - 8'h01 &&
             arith_flags.carry_flag == ($past(working_register, 3) == 8'h00));
    endproperty
    a_dec_acc: assert property (p_dec_acc)
        else $error("decrement wrong");
endmodule

bind bsie_core bsie_core_props i_bsie_core_props (.*);

// ---- verification/bsie_core_test.sv ----
// Self-checking bench for the bit and skip execution block
`timescale 1ns/1ps
`include "bsie_map.svh"
module bsie_core_test;
    import bsie_pkg::*;

    // Design ports
    logic        clk, nrst, ce, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address, port_a, port_b, working_register;
    logic [31:0] avs_writedata, avs_readdata, seen;
    logic [3:0]  avs_byteenable;
    bsie_flags_t arith_flags;
    int          bad_count, compares;
    typedef struct packed {
        bsie_op_t op; logic [2:0] b; logic [5:0] a; logic [7:0] imm;
        logic [7:0] acc_in; logic skip; logic [3:0] flg; logic [7:0] acc_out;
    } bsie_case_t;
    // Skip cases: port_a d8, mem5 01, mem7 ff
    bsie_case_t  cases [18] = '{
        '{test_low_skip_io, 3'd0, 6'd0, 8'h00, 8'h00, 1'b1, 4'ha, 8'h00},
        '{test_low_skip_io, 3'd3, 6'd0, 8'h00, 8'h00, 1'b0, 4'ha, 8'h00},
        '{test_high_skip_io, 3'd3, 6'd0, 8'h00, 8'h00, 1'b1, 4'ha, 8'h00},
        '{test_high_skip_io, 3'd0, 6'd0, 8'h00, 8'h00, 1'b0, 4'ha, 8'h00},
        '{test_low_skip_mem, 3'd1, 6'd5, 8'h00, 8'h00, 1'b1, 4'ha, 8'h00},
        '{test_low_skip_mem, 3'd0, 6'd5, 8'h00, 8'h00, 1'b0, 4'ha, 8'h00},
        '{test_high_skip_mem, 3'd0, 6'd5, 8'h00, 8'h00, 1'b1, 4'ha, 8'h00},
        '{test_high_skip_mem, 3'd1, 6'd5, 8'h00, 8'h00, 1'b0, 4'ha, 8'h00},
        '{cmp_imm_skip, 3'd0, 6'd0, 8'h3c, 8'h3c, 1'b1, 4'h1, 8'h3c},
        '{cmp_imm_skip, 3'd0, 6'd0, 8'h3d, 8'h3c, 1'b0, 4'h6, 8'h3c},
        '{cmp_mem_skip, 3'd0, 6'd5, 8'h00, 8'h80, 1'b0, 4'hc, 8'h80},
        '{cmp_mem_skip, 3'd0, 6'd5, 8'h00, 8'h01, 1'b1, 4'h1, 8'h01},
        '{inc_acc_skip, 3'd0, 6'd0, 8'h00, 8'hff, 1'b1, 4'h7, 8'h00},
        '{inc_acc_skip, 3'd0, 6'd0, 8'h00, 8'h7f, 1'b0, 4'hc, 8'h80},
        '{dec_acc_skip, 3'd0, 6'd0, 8'h00, 8'h01, 1'b1, 4'h1, 8'h00},
        '{dec_acc_skip, 3'd0, 6'd0, 8'h00, 8'h00, 1'b0, 4'h6, 8'hff},
        '{inc_mem_skip, 3'd0, 6'd7, 8'h00, 8'h55, 1'b1, 4'h7, 8'h55},
        '{dec_mem_skip, 3'd0, 6'd7, 8'h00, 8'h55, 1'b0, 4'h6, 8'h55}
    };

    bsie_core i_bsie_core (.*);

    ////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus transfer; request held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        seen = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, seen);
    endtask

    // Command write, then poll busy with a bound
    task automatic exec(input bsie_op_t op, input logic [2:0] b, input logic [5:0] a,
                        input logic [7:0] imm);
        bsie_cmd_t c;
        int n;
        c = '0;
        c.op = op;
        c.bit_idx = b;
        c.addr = a;
        c.imm = imm;
        xfer(1'b1, `BSIE_REG_CMD, 32'(c), 4'hf);
        n = 0;
        do begin
            xfer(1'b0, `BSIE_REG_STATUS, 32'h0, 4'hf);
            n++;
        end while (seen[`BSIE_STAT_BUSY] !== 1'b0 && n < 10);
        if (n >= 10) begin
            bad_count++;
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0; ce = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 8'h00; avs_writedata = 32'h0; avs_byteenable = 4'h0;
        bad_count = 0; compares = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // Reset values
        rd_chk("acc", `BSIE_REG_ACC, 32'h0);
        rd_chk("flags", `BSIE_REG_FLAGS, 32'h0);
        rd_chk("status", `BSIE_REG_STATUS, 32'h0);
        chk("port_a", 32'h0, {24'h0, port_a});
        // Lane mask and unmapped place
        xfer(1'b1, `BSIE_REG_IO_BASE, 32'h5a, 4'hf);
        xfer(1'b1, `BSIE_REG_IO_BASE, 32'hff, 4'h0);
        rd_chk("io0", `BSIE_REG_IO_BASE, 32'h5a);
        xfer(1'b1, 8'h40, 32'hffffffff, 4'hf);
        rd_chk("unmapped", 8'h40, 32'h0);
        // Bit set and clear on IO and memory, flags kept
        xfer(1'b1, `BSIE_REG_FLAGS, 32'ha, 4'hf);
        exec(clear_bit_op_io, 3'd1, 6'd0, 8'h00);
        chk("port_a", 32'h58, {24'h0, port_a});
        exec(assert_bit_op_io, 3'd7, 6'd0, 8'h00);
        chk("port_a", 32'hd8, {24'h0, port_a});
        exec(assert_bit_op_io, 3'd0, 6'd1, 8'h00);
        chk("port_b", 32'h01, {24'h0, port_b});
        exec(mem_load, 3'd0, 6'd5, 8'h20);
        exec(clear_bit_op_mem, 3'd5, 6'd5, 8'h00);
        exec(assert_bit_op_mem, 3'd0, 6'd5, 8'h00);
        exec(mem_fetch, 3'd0, 6'd5, 8'h00);
        rd_chk("mem5", `BSIE_REG_RESULT, 32'h01);
        rd_chk("flags", `BSIE_REG_FLAGS, 32'ha);
        exec(mem_load, 3'd0, 6'd7, 8'hff);
        // Each case: tested op, then a follower setting bit 3 of IO register 2
        foreach (cases[i]) begin
            xfer(1'b1, `BSIE_REG_IO_BASE + 8'h08, 32'h0, 4'hf);
            xfer(1'b1, `BSIE_REG_FLAGS, 32'ha, 4'hf);
            xfer(1'b1, `BSIE_REG_ACC, {24'h0, cases[i].acc_in}, 4'hf);
            exec(cases[i].op, cases[i].b, cases[i].a, cases[i].imm);
            rd_chk("acc", `BSIE_REG_ACC, {24'h0, cases[i].acc_out});
            rd_chk("flags", `BSIE_REG_FLAGS, {28'h0, cases[i].flg});
            xfer(1'b0, `BSIE_REG_STATUS, 32'h0, 4'hf);
            chk("pending", {31'h0, cases[i].skip}, {31'h0, seen[`BSIE_STAT_PEND]});
            exec(assert_bit_op_io, 3'd3, 6'd2, 8'h00);
            rd_chk("io2", `BSIE_REG_IO_BASE + 8'h08, cases[i].skip ? 32'h0 : 32'h8);
            xfer(1'b0, `BSIE_REG_STATUS, 32'h0, 4'hf);
            chk("cancel", {31'h0, cases[i].skip}, {31'h0, seen[`BSIE_STAT_SKIPPED]});
        end
        exec(mem_fetch, 3'd0, 6'd7, 8'h00);
        rd_chk("mem7", `BSIE_REG_RESULT, 32'hff);
        wrap_up();
    end
endmodule
